// ---- hdl/rlc_params.svh ----
// Purpose: Constants of the redistributor message-interrupt control block
// Assumes: One core_clk domain, 4 ns period
// Notes: Offsets are byte addresses inside the control frame
`ifndef RLC_PARAMS_SVH
`define RLC_PARAMS_SVH

`define RLC_ADDR_W 16
`define RLC_CTLR_OFS 16'h0000
`define RLC_CLR_OFS 16'h0048
`define RLC_UWP_BIT 31
`define RLC_OPT_LSB 24
`define RLC_RWP_BIT 3
`define RLC_EN_BIT 0
`define RLC_MSG_NUM 32
`define RLC_IDX_W 5
`define RLC_ID_BASE 32'h0000_2000
`define RLC_CLK_NS 4
`define RLC_PROP_NS 32
`define RLC_PROP_CYC ((`RLC_PROP_NS + `RLC_CLK_NS - 1) / `RLC_CLK_NS)
`define RLC_CNT_W 4

`endif

// ---- hdl/rlc_pkg.sv ----
// Purpose: Types of the redistributor message-interrupt control block
// Assumes: rlc_params.svh holds all numbers
// Notes: Group index 0 is group zero, 1 non-secure one, 2 secure one
package rlc_pkg;

    typedef enum logic [0:0] {
        RLC_IDLE = 1'b0,
        RLC_LOAD = 1'b1
    } rlc_fsm_t;

    typedef struct packed {
        logic enable;
        logic [2:0] optout;
        logic [3:0] rwp_cnt;
        rlc_fsm_t fsm;
        logic fetch_req;
        logic are_ns_d;
        logic [31:0] rdata;
        logic rvalid;
        logic doorbell;
        logic [2:0] eligible;
        logic [2:0] reselect;
    } rlc_ctl_t;

    typedef struct packed {
        logic [31:0] pend;
    } rlc_store_t;

endpackage

// ---- hdl/rlc_pend_if.sv ----
// Purpose: Carrier between control logic and the pending store
// Assumes: Single clock, same domain on both sides
// Notes: Index is relative to the first implemented identifier
`timescale 1ns/100ps
interface rlc_pend_if;
    logic set_valid;
    logic [4:0] set_idx;
    logic clr_valid;
    logic [4:0] clr_idx;
    logic load_valid;
    logic [31:0] load_word;
    logic [31:0] pend;

    modport ctl (
        output set_valid, set_idx, clr_valid, clr_idx, load_valid, load_word,
        input pend
    );
    modport store (
        input set_valid, set_idx, clr_valid, clr_idx, load_valid, load_word,
        output pend
    );
endinterface

// ---- hdl/rlc_pend_store.sv ----
// Purpose: Pending state of the implemented message interrupts
// Assumes: Clear is only presented when the bit is pending
// Notes: Set and table load win over a clear of the same bit
`timescale 1ns/100ps
module rlc_pend_store (
    input wire logic core_clk,
    input wire logic sys_rst,
    rlc_pend_if.store pif
);

    rlc_pkg::rlc_store_t st_ff;
    rlc_pkg::rlc_store_t nxt_st;

    // ==========================================================
    // Update
    // ==========================================================
    always_comb begin
        logic [31:0] set_vec;
        logic [31:0] clr_vec;
        set_vec = '0;
        clr_vec = '0;
        if (pif.set_valid) begin
            set_vec[pif.set_idx] = 1'b1;
        end
        if (pif.load_valid) begin
            set_vec = set_vec | pif.load_word;
        end
        if (pif.clr_valid) begin
            clr_vec[pif.clr_idx] = 1'b1;
        end
        // Single read-modify-write, set beats clear
        nxt_st.pend = (st_ff.pend & ~clr_vec) | set_vec;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pif.pend = st_ff.pend;

    // ==========================================================
    // Checks
    // ==========================================================
    chk_clear_drops_bit: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (pif.clr_valid && !pif.load_valid &&
         !(pif.set_valid && pif.set_idx == pif.clr_idx))
        |=> !st_ff.pend[$past(pif.clr_idx)])
        else $error("accepted clear left bit pending");

    chk_set_not_lost: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        pif.set_valid |=> st_ff.pend[$past(pif.set_idx)])
        else $error("concurrent set was lost");

endmodule

// ---- hdl/rlc_top.sv ----
// Purpose: Redistributor control register and message-interrupt clear port
// Assumes: Register port and distributor signals share core_clk
// Notes: Pending table fetch is one 32-bit word for the implemented range
`timescale 1ns/100ps
`include "rlc_params.svh"
module rlc_top (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [63:0] reg_wdata,
    input wire logic reg_wide,
    input wire logic reg_secure,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic select_optout_capability,
    input wire logic message_irq_capability,
    input wire logic single_security_state,
    input wire logic nonsecure_affinity_routing_enable,
    input wire logic wake_on_one_of_n,
    input wire logic processor_sleep_flag,
    input wire logic [2:0] grp_enable,
    input wire logic [4:0] identifier_bits_setting,
    input wire logic per_cpu_enable_clear_wr,
    input wire logic upstream_busy,
    input wire logic msg_set_valid,
    input wire logic [31:0] msg_set_id,
    input wire logic doorbell_in,
    input wire logic tbl_fetch_valid,
    input wire logic [31:0] tbl_fetch_data,
    output logic tbl_fetch_req,
    output logic message_irq_enable,
    output logic doorbell_out,
    output logic [31:0] msg_pending,
    output logic [2:0] select_eligible,
    output logic [2:0] reselect_req
);

    rlc_pkg::rlc_ctl_t st_ff;
    rlc_pkg::rlc_ctl_t nxt_st;
    rlc_pend_if pif ();

    rlc_pend_store u_store (
        .core_clk (core_clk),
        .sys_rst (sys_rst),
        .pif (pif)
    );

    // ==========================================================
    // Helpers
    // ==========================================================
    // Bits above the identifier width read as zero
    function automatic logic [31:0] id_mask(
        input logic [31:0] id,
        input logic [4:0] bits
    );
        logic [31:0] m;
        m = 32'hFFFF_FFFF >> (5'd31 - bits);
        return id & m;
    endfunction

    function automatic logic id_ok(input logic [31:0] id);
        return (id >= `RLC_ID_BASE) &&
            (id - `RLC_ID_BASE < 32'(`RLC_MSG_NUM));
    endfunction

    function automatic logic [4:0] id_idx(input logic [31:0] id);
        logic [31:0] d;
        d = id - `RLC_ID_BASE;
        return d[4:0];
    endfunction

    // Access rights per opt-out bit: 0 grp0, 1 grp1 ns, 2 grp1 s
    function automatic logic opt_access(
        input int i,
        input logic ds,
        input logic sec
    );
        if (i == 2) begin
            return !ds && sec;
        end else if (i == 0) begin
            return ds || sec;
        end
        return 1'b1;
    endfunction

    // ==========================================================
    // Decode
    // ==========================================================
    logic wr_ctlr;
    logic wr_clr;
    logic rd_ctlr;
    logic [63:0] clr_val;
    logic [31:0] clr_id;
    logic en_allowed;
    logic [2:0] opt_eff;

    assign wr_ctlr = reg_wr && (reg_addr == `RLC_CTLR_OFS);
    assign wr_clr = reg_wr && (reg_addr == `RLC_CLR_OFS);
    assign rd_ctlr = reg_rd && (reg_addr == `RLC_CTLR_OFS);
    // Narrow write leaves the upper word zero
    assign clr_val = reg_wide ? reg_wdata : {32'h0000_0000, reg_wdata[31:0]};
    // Reserved upper word is not part of the identifier
    assign clr_id = id_mask(clr_val[31:0], identifier_bits_setting);
    assign en_allowed = message_irq_capability &&
        nonsecure_affinity_routing_enable;
    // Secure group-one bit is dead in single-state mode
    // Absent capability hides all three bits
    assign opt_eff = {st_ff.optout[2] && !single_security_state,
        st_ff.optout[1:0]} & {3{select_optout_capability}};

    // Pending store requests
    always_comb begin
        pif.clr_valid = wr_clr && st_ff.enable && id_ok(clr_id) &&
            pif.pend[id_idx(clr_id)];
        pif.clr_idx = id_idx(clr_id);
        // Translation sets are dropped while disabled
        pif.set_valid = msg_set_valid && st_ff.enable && id_ok(msg_set_id);
        pif.set_idx = id_idx(msg_set_id);
        pif.load_valid = (st_ff.fsm == rlc_pkg::RLC_LOAD) && tbl_fetch_valid
            && st_ff.enable;
        pif.load_word = tbl_fetch_data;
    end

    // ==========================================================
    // Control state
    // ==========================================================
    always_comb begin
        logic [31:0] rd;
        logic opt_chg;
        rd = 32'h0000_0000;
        nxt_st = st_ff;
        opt_chg = 1'b0;
        nxt_st.are_ns_d = nonsecure_affinity_routing_enable;

        // Opt-out writes, only with the capability present
        if (wr_ctlr && select_optout_capability) begin
            for (int i = 0; i < 3; i++) begin
                if (opt_access(i, single_security_state, reg_secure)) begin
                    nxt_st.optout[i] = reg_wdata[`RLC_OPT_LSB + i];
                end
            end
        end
        opt_chg = (nxt_st.optout != st_ff.optout);
        // Reselect forwarded interrupts of a changed group
        nxt_st.reselect = nxt_st.optout ^ st_ff.optout;

        // Propagation window after an opt-out change or enable-clear write
        if (opt_chg || per_cpu_enable_clear_wr) begin
            nxt_st.rwp_cnt = 4'(`RLC_PROP_CYC);
        end else if (st_ff.rwp_cnt != 4'h0) begin
            nxt_st.rwp_cnt = st_ff.rwp_cnt - 4'h1;
        end

        // Writes only set the enable, writing zero leaves it set
        if (wr_ctlr && en_allowed && !st_ff.enable &&
            reg_wdata[`RLC_EN_BIT]) begin
            nxt_st.enable = 1'b1;
            nxt_st.fsm = rlc_pkg::RLC_LOAD;
            nxt_st.fetch_req = 1'b1;
        end
        // Routing drop clears the enable, the fixed choice
        if (st_ff.are_ns_d && !nonsecure_affinity_routing_enable) begin
            nxt_st.enable = 1'b0;
        end
        // Reserved as zero without support
        if (!message_irq_capability) begin
            nxt_st.enable = 1'b0;
        end

        // Pending table fetch
        case (st_ff.fsm)
            rlc_pkg::RLC_IDLE: begin
                if (nxt_st.fsm == rlc_pkg::RLC_IDLE) begin
                    nxt_st.fetch_req = 1'b0;
                end
            end
            rlc_pkg::RLC_LOAD: begin
                // Abort if the enable went away mid-fetch
                if (tbl_fetch_valid || !nxt_st.enable) begin
                    nxt_st.fsm = rlc_pkg::RLC_IDLE;
                    nxt_st.fetch_req = 1'b0;
                end
            end
            default: begin
                nxt_st.fsm = rlc_pkg::RLC_IDLE;
                nxt_st.fetch_req = 1'b0;
            end
        endcase

        // Doorbells only pass while enabled
        nxt_st.doorbell = doorbell_in && st_ff.enable;

        // One-of-N eligibility, opt-out regardless of routing
        for (int i = 0; i < 3; i++) begin
            nxt_st.eligible[i] = grp_enable[i] && !opt_eff[i] &&
                (!processor_sleep_flag || wake_on_one_of_n);
        end

        // Read path, one cycle latency
        if (rd_ctlr) begin
            rd[`RLC_UWP_BIT] = upstream_busy;
            rd[`RLC_OPT_LSB + 2] = opt_eff[2] && !single_security_state
                && reg_secure;
            rd[`RLC_OPT_LSB + 1] = opt_eff[1];
            rd[`RLC_OPT_LSB] = opt_eff[0] &&
                (single_security_state || reg_secure);
            rd[`RLC_RWP_BIT] = (st_ff.rwp_cnt != 4'h0);
            rd[`RLC_EN_BIT] = st_ff.enable && en_allowed;
        end
        nxt_st.rdata = rd;
        nxt_st.rvalid = reg_rd;
    end

    // Opt-out bits reset to zero
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign reg_rdata = st_ff.rdata;
    assign reg_rvalid = st_ff.rvalid;
    assign tbl_fetch_req = st_ff.fetch_req;
    assign message_irq_enable = st_ff.enable;
    assign doorbell_out = st_ff.doorbell;
    assign msg_pending = pif.pend;
    assign select_eligible = st_ff.eligible;
    assign reselect_req = st_ff.reselect;

    // ==========================================================
    // Checks
    // ==========================================================
    chk_clear_when_off: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (wr_clr && !st_ff.enable) |-> !pif.clr_valid)
        else $error("clear accepted while disabled");

    chk_enable_sticks: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (st_ff.enable && nonsecure_affinity_routing_enable &&
         message_irq_capability)
        ##1 (nonsecure_affinity_routing_enable && message_irq_capability)
        |-> st_ff.enable)
        else $error("enable dropped without cause");

    chk_fetch_on_enable: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        $rose(st_ff.enable) |-> tbl_fetch_req)
        else $error("no table fetch on enable");

    chk_rwp_window: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (st_ff.optout != $past(st_ff.optout))
        |-> (st_ff.rwp_cnt != 4'h0) [*8])
        else $error("write pending too short");

    chk_optout_absent: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (wr_ctlr && !select_optout_capability) |=> $stable(st_ff.optout))
        else $error("opt-out written without capability");

    chk_ns_g1s_wi: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (wr_ctlr && !reg_secure) |=> $stable(st_ff.optout[2]))
        else $error("non-secure wrote secure opt-out");

    chk_uwp_read: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        rd_ctlr |=> reg_rvalid && reg_rdata[31] == $past(upstream_busy))
        else $error("upstream pending misreported");

    chk_sleep_blocks: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (processor_sleep_flag && !wake_on_one_of_n)
        |=> select_eligible == 3'h0)
        else $error("sleeping processor eligible");

    chk_doorbell_gate: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        !st_ff.enable |=> !doorbell_out)
        else $error("doorbell passed while disabled");

    chk_reselect_on_change: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (st_ff.optout != $past(st_ff.optout)) |-> (reselect_req != 3'h0))
        else $error("opt-out change without reselect");

    chk_optout_raz_absent: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (rd_ctlr && !select_optout_capability)
        |=> reg_rdata[`RLC_OPT_LSB +: 3] == 3'h0)
        else $error("opt-out bits read without capability");

    chk_enable_raz: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (rd_ctlr && !en_allowed) |=> !reg_rdata[`RLC_EN_BIT])
        else $error("enable read as set while reserved");

endmodule

// ---- sim/rlc_dist_model.sv ----
// Purpose: Distributor and memory side of the control block
// Assumes: Table fetch answered after fetch_delay+1 edges
// Notes: Data bus walks a changing filler outside the valid pulse
`timescale 1ns/100ps
// ====================================
// Pending table responder
module rlc_dist_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic tbl_fetch_req,
    input wire logic [3:0] fetch_delay,
    input wire logic [31:0] table_word,
    output logic tbl_fetch_valid,
    output logic [31:0] tbl_fetch_data
);
    logic [3:0] cnt_ff;
    always_ff @(posedge core_clk) begin
        // Filler changes every cycle so stale data never looks valid
        tbl_fetch_data <= {tbl_fetch_data[30:0], ~tbl_fetch_data[31]};
        tbl_fetch_valid <= 1'b0;
        // Seed the filler so the idle bus is never unknown
        if (sys_rst) begin
            tbl_fetch_data <= 32'h5A5A_C3C3;
        end
        if (sys_rst || !tbl_fetch_req || tbl_fetch_valid) begin
            cnt_ff <= 4'h0;
        end else if (cnt_ff == fetch_delay) begin
            tbl_fetch_valid <= 1'b1;
            tbl_fetch_data <= table_word;
            cnt_ff <= 4'h0;
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end
endmodule

// ---- sim/tb_redistributor_lpi_control.sv ----
// Purpose: Self-checking bench of the control block
// Assumes: Inputs change at the falling edge of core_clk
// Notes: Expected values follow the control and clear port layout
`timescale 1ns/100ps
// ====================================
// Bench top
module tb_redistributor_lpi_control;
    logic core_clk, sys_rst, reg_wr, reg_rd, reg_wide, reg_secure;
    logic [15:0] reg_addr;
    logic [63:0] reg_wdata;
    logic [31:0] reg_rdata, msg_set_id, tbl_fetch_data, msg_pending, word;
    logic reg_rvalid, select_optout_capability, message_irq_capability;
    logic single_security_state, nonsecure_affinity_routing_enable;
    logic wake_on_one_of_n, processor_sleep_flag, per_cpu_enable_clear_wr;
    logic upstream_busy, msg_set_valid, doorbell_in, tbl_fetch_valid;
    logic tbl_fetch_req, message_irq_enable, doorbell_out;
    logic [2:0] grp_enable, select_eligible, reselect_req;
    logic [4:0] identifier_bits_setting;
    logic [3:0] dly;
    int err_count = 0;
    int checked = 0;

    rlc_top rlc_top_i (.core_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_wide, .reg_secure, .reg_rdata, .reg_rvalid,
        .select_optout_capability, .message_irq_capability,
        .single_security_state, .nonsecure_affinity_routing_enable,
        .wake_on_one_of_n, .processor_sleep_flag, .grp_enable,
        .identifier_bits_setting, .per_cpu_enable_clear_wr, .upstream_busy,
        .msg_set_valid, .msg_set_id, .doorbell_in, .tbl_fetch_valid,
        .tbl_fetch_data, .tbl_fetch_req, .message_irq_enable, .doorbell_out,
        .msg_pending, .select_eligible, .reselect_req);
    rlc_dist_model rlc_dist_model_i (.core_clk, .sys_rst, .tbl_fetch_req,
        .fetch_delay(dly), .table_word(word), .tbl_fetch_valid,
        .tbl_fetch_data);

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic finish_test;
        if (err_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [63:0] d,
                      input logic wide, input logic sec);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        reg_wide = wide;
        reg_secure = sec;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic sec, input logic [31:0] exp);
        @(negedge core_clk);
        reg_rd = 1'b1;
        reg_addr = 16'h0000;
        reg_secure = sec;
        @(negedge core_clk);
        reg_rd = 1'b0;
        cmp((reg_rvalid === 1'b1) ? reg_rdata : 32'hDEAD_BEEF, exp);
    endtask

    task automatic setm(input logic [31:0] id);
        @(negedge core_clk);
        msg_set_valid = 1'b1;
        msg_set_id = id;
        @(negedge core_clk);
        msg_set_valid = 1'b0;
    endtask

    task automatic bell(input logic exp);
        @(negedge core_clk);
        doorbell_in = 1'b1;
        @(negedge core_clk);
        doorbell_in = 1'b0;
        cmp({31'h0, doorbell_out}, {31'h0, exp});
    endtask

    // Fetch wait is bounded; a stuck request shows as a mismatch
    task automatic enable_and_fetch(input logic [31:0] exp);
        wr(16'h0000, 64'h1, 1'b0, 1'b1);
        cmp({30'h0, message_irq_enable, tbl_fetch_req}, 32'h3);
        for (int i = 0; i < 20 && tbl_fetch_req !== 1'b0; i++) begin
            cyc(1);
        end
        cyc(1);
        cmp(msg_pending, exp);
    endtask

    initial begin
        #40000;
        err_count = err_count + 1;
        finish_test();
    end

    initial begin
        sys_rst = 1'b1;
        {reg_wr, reg_rd, reg_wide, reg_secure} = 4'h0;
        reg_addr = 16'h0000;
        reg_wdata = 64'h0;
        {select_optout_capability, message_irq_capability} = 2'h3;
        {single_security_state, wake_on_one_of_n} = 2'h0;
        nonsecure_affinity_routing_enable = 1'b1;
        {processor_sleep_flag, per_cpu_enable_clear_wr} = 2'h0;
        {upstream_busy, msg_set_valid, doorbell_in} = 3'h0;
        grp_enable = 3'h7;
        identifier_bits_setting = 5'hD;
        msg_set_id = 32'h0;
        word = 32'h0000_0089;
        dly = 4'h5;
        cyc(4);
        sys_rst = 1'b0;
        rd(1'b1, 32'h0);
        cmp(msg_pending, 32'h0);
        upstream_busy = 1'b1;
        rd(1'b1, 32'h8000_0000);
        upstream_busy = 1'b0;
        // Opt-out bits, access rights and write pending
        wr(16'h0000, 64'h0700_0000, 1'b0, 1'b1);
        cmp({29'h0, reselect_req}, 32'h7);
        rd(1'b1, 32'h0700_0008);
        cyc(10);
        rd(1'b1, 32'h0700_0000);
        rd(1'b0, 32'h0200_0000);
        nonsecure_affinity_routing_enable = 1'b0;
        cyc(2);
        cmp({29'h0, select_eligible}, 32'h0);
        nonsecure_affinity_routing_enable = 1'b1;
        wr(16'h0000, 64'h0, 1'b0, 1'b0);
        cmp({29'h0, reselect_req}, 32'h2);
        cyc(10);
        rd(1'b1, 32'h0500_0000);
        cmp({29'h0, select_eligible}, 32'h2);
        wr(16'h0000, 64'h0, 1'b0, 1'b1);
        cyc(10);
        cmp({29'h0, select_eligible}, 32'h7);
        processor_sleep_flag = 1'b1;
        cyc(3);
        cmp({29'h0, select_eligible}, 32'h0);
        wake_on_one_of_n = 1'b1;
        cyc(3);
        cmp({29'h0, select_eligible}, 32'h7);
        {processor_sleep_flag, wake_on_one_of_n} = 2'h0;
        per_cpu_enable_clear_wr = 1'b1;
        cyc(1);
        per_cpu_enable_clear_wr = 1'b0;
        rd(1'b1, 32'h0000_0008);
        cyc(10);
        single_security_state = 1'b1;
        wr(16'h0000, 64'h0700_0000, 1'b0, 1'b1);
        cyc(10);
        rd(1'b1, 32'h0300_0000);
        wr(16'h0000, 64'h0, 1'b0, 1'b1);
        single_security_state = 1'b0;
        select_optout_capability = 1'b0;
        wr(16'h0000, 64'h0700_0000, 1'b0, 1'b1);
        cyc(10);
        rd(1'b1, 32'h0);
        select_optout_capability = 1'b1;
        // Enable refused without capability or routing
        nonsecure_affinity_routing_enable = 1'b0;
        wr(16'h0000, 64'h1, 1'b0, 1'b1);
        message_irq_capability = 1'b0;
        nonsecure_affinity_routing_enable = 1'b1;
        wr(16'h0000, 64'h1, 1'b0, 1'b1);
        rd(1'b1, 32'h0);
        message_irq_capability = 1'b1;
        bell(1'b0);
        setm(32'h0000_2001);
        cmp(msg_pending, 32'h0);
        enable_and_fetch(32'h0000_0089);
        wr(16'h0000, 64'h0, 1'b0, 1'b1);
        rd(1'b1, 32'h1);
        bell(1'b1);
        // Clear port: width, reserved and masked bits, refusals
        wr(16'h0048, 64'hFFFF_FFFF_0000_2003, 1'b1, 1'b0);
        cyc(1);
        cmp(msg_pending, 32'h0000_0081);
        wr(16'h0048, 64'h5555_0000_0001_2007, 1'b0, 1'b0);
        cyc(1);
        cmp(msg_pending, 32'h0000_0001);
        wr(16'h0048, 64'h2020, 1'b1, 1'b0);
        wr(16'h0048, 64'h2005, 1'b1, 1'b0);
        cyc(1);
        cmp(msg_pending, 32'h0000_0001);
        setm(32'h0000_2004);
        @(negedge core_clk);
        {reg_wr, msg_set_valid, reg_wide} = 3'h7;
        reg_addr = 16'h0048;
        reg_wdata = 64'h2000;
        msg_set_id = 32'h0000_2000;
        @(negedge core_clk);
        {reg_wr, msg_set_valid} = 2'h0;
        cyc(1);
        cmp(msg_pending, 32'h0000_0011);
        nonsecure_affinity_routing_enable = 1'b0;
        cyc(2);
        cmp({31'h0, message_irq_enable}, 32'h0);
        nonsecure_affinity_routing_enable = 1'b1;
        wr(16'h0048, 64'h2000, 1'b1, 1'b0);
        cyc(1);
        cmp(msg_pending, 32'h0000_0011);
        bell(1'b0);
        dly = 4'h0;
        word = 32'h0000_0100;
        enable_and_fetch(32'h0000_0111);
        finish_test();
    end
endmodule
